// *** regbank_pkg.sv ***
// regulator control register bank: shared constants and carrier types
// assumes an 8-bit register port fed by the serial bus front end
package regbank_pkg;

	// =========================================================
	// sizes
	localparam int NUM_REG   = 10;  // regulators three to twelve
	localparam int NUM_DVS   = 2;   // switching regulators with two codes
	localparam int CODE_W    = 6;
	localparam int DATA_W    = 8;

	// =========================================================
	// register offsets
	localparam logic [7:0] OFS_REG3_PRIMARY   = 8'h30;
	localparam logic [7:0] OFS_REG3_SECONDARY = 8'h31;
	localparam logic [7:0] OFS_REG4_SECONDARY = 8'h41;
	localparam logic [7:0] OFS_REG13_ENABLE   = 8'hB1;
	localparam logic [7:0] OFS_BUTTON_CTRL    = 8'hC0;
	localparam logic [7:0] OFS_IRQ_SOURCE     = 8'hC1;
	localparam logic [7:0] OFS_BUTTON_STATUS  = 8'hC2;
	// voltage and control offsets per regulator, index 0 is regulator three
	localparam logic [NUM_REG-1:0][7:0] OFS_VOLT = {
		8'hA0, 8'h90, 8'h80, 8'h70, 8'h68, 8'h60, 8'h58, 8'h50, 8'h40, 8'h30};
	localparam logic [NUM_REG-1:0][7:0] OFS_CTRL = {
		8'hA1, 8'h91, 8'h81, 8'h71, 8'h69, 8'h61, 8'h59, 8'h51, 8'h42, 8'h32};
	localparam logic [NUM_DVS-1:0][7:0] OFS_SEC = {OFS_REG4_SECONDARY, OFS_REG3_SECONDARY};

	// =========================================================
	// field positions
	localparam int BIT_ON       = 7;
	localparam int BIT_OPTION   = 2;   // phase on switchers, discharge on linears
	localparam int BIT_FLT_EN   = 1;
	localparam int BIT_PGOOD    = 0;
	localparam int BIT_PRESS    = 7;
	localparam int BIT_RELEASE  = 6;
	localparam int BIT_LIVE     = 5;

	// =========================================================
	// reset values
	localparam logic [NUM_REG-1:0][CODE_W-1:0] RST_CODE = {
		6'h24, 6'h24, 6'h18, 6'h18, 6'h24, 6'h39, 6'h39, 6'h34, 6'h39, 6'h19};
	localparam logic [NUM_DVS-1:0][CODE_W-1:0] RST_SEC = {6'h39, 6'h19};
	localparam logic [NUM_REG-1:0] RST_ON     = 10'h38F;
	localparam logic [NUM_REG-1:0] RST_OPTION = 10'h3FF;
	localparam logic [NUM_REG-1:0] RST_FLT_EN = 10'h000;
	localparam logic               RST_REG13  = 1'b1;
	localparam logic [7:0]         IRQ_NONE   = 8'hFF;

	// =========================================================
	// carriers
	typedef struct packed {
		logic [7:0]        addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              valid;
	} reg_rsp_t;

endpackage

// *** dvs_select.sv ***
// per-regulator choice between primary and secondary voltage code
// assumes the bank select pin is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dvs_select #(
	parameter int N = 2,
	parameter int W = 6
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// codes and selector
	input  wire logic [N-1:0][W-1:0]  primary,
	input  wire logic [N-1:0][W-1:0]  secondary,
	input  wire logic                 bank_sel,
	// applied code
	output logic      [N-1:0][W-1:0]  applied
);
	typedef struct packed {
		logic [N-1:0][W-1:0] code;
	} dvs_state_t;

	dvs_state_t state_r;
	dvs_state_t state_nxt;

	// =========================================================
	// selection, one lane per regulator
	always_comb
	begin
		state_nxt = state_r;
		for (int i = 0; i < N; i++)
		begin
			state_nxt.code[i] = bank_sel ? secondary[i] : primary[i]; // R1 R2
		end
	end

	// registered so the analog side never sees a mux glitch
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign applied = state_r.code;
endmodule
`default_nettype wire

// *** button_event.sv ***
// push-button edge detection with sticky press and release flags
// assumes the button input is already debounced and synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module button_event (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// button and enables
	input  wire logic push_button_input_n,
	input  wire logic press_en,
	input  wire logic release_en,
	input  wire logic flag_clear,
	// flags
	output logic      press_flag,
	output logic      release_flag,
	output logic      live,
	output logic      event_pulse
);
	typedef struct packed {
		logic prev;
		logic press;
		logic release_f;
		logic evt;
	} btn_state_t;

	btn_state_t state_r;
	btn_state_t state_nxt;
	logic       asserted;
	logic       rise;
	logic       fall;

	assign asserted = ~push_button_input_n;
	assign rise     = asserted & ~state_r.prev;
	assign fall     = ~asserted & state_r.prev;

	// =========================================================
	// a new edge wins over a clear landing in the same cycle
	always_comb
	begin
		state_nxt      = state_r;
		state_nxt.prev = asserted;
		if (flag_clear)
		begin
			state_nxt.press     = 1'b0;
			state_nxt.release_f = 1'b0;
		end
		if (rise && press_en)
			state_nxt.press = 1'b1;         // R9 R11
		if (fall && release_en)
			state_nxt.release_f = 1'b1;     // R10
		state_nxt.evt = (rise && press_en) || (fall && release_en);
	end

	// prev resets as released, so a button held through reset gives a rise on the first cycle after it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign press_flag   = state_r.press;
	assign release_flag = state_r.release_f;
	assign live         = state_r.prev;
	assign event_pulse  = state_r.evt;
endmodule
`default_nettype wire

// *** regbank_top.sv ***
// regulator control register bank: registers, fault capture, irq output
// assumes the serial front end issues one-cycle read and write strobes
// Operation
// R1 - A switching regulator applies its secondary code while the bank select pin is high.
// R2 - A switching regulator applies its primary code while the bank select pin is low.
// R3 - Bit seven of each control register, regulator thirteen included, turns it on or off.
// R4 - Bit two of a switching regulator's control register sets 180 degree phase.
// R5 - Bit one of each control register lets that regulator's faults raise interrupts.
// R6 - Bit zero reads the live power-good level and ignores writes.
// R7 - Bit two of a linear regulator's control register enables discharge when off.
// R8 - Each linear voltage register holds a six-bit code with two zero read-only top bits.
// R9 - Button control bit seven enables an interrupt on button press.
// R10 - Button control bit six enables an interrupt on button release.
// R11 - A read-only press flag goes to one once the press interrupt has fired.
// R12 - The irq source register names the block, reads 0xFF idle and returns to it after a read.
// R13 - Reserved bits read zero and writes to them are dropped.
// R14 - The shared interrupt output stays asserted while any enabled source is pending.
`timescale 1ns/1ps
`default_nettype none
module regbank_top
(
	// clock and reset
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	// register port from the serial front end
	input  wire regbank_pkg::reg_req_t                 reg_req,
	output regbank_pkg::reg_rsp_t                      reg_rsp,
	// analog status
	input  wire logic [regbank_pkg::NUM_REG-1:0]       power_good,
	input  wire logic [regbank_pkg::NUM_REG-1:0]       regulator_fault,
	// pins
	input  wire logic                                  voltage_bank_select_pin,
	input  wire logic                                  push_button_input_n,
	output logic                                       irq_n,
	// regulator controls
	output logic [regbank_pkg::NUM_REG-1:0][regbank_pkg::CODE_W-1:0] output_voltage_code,
	output logic [regbank_pkg::NUM_REG-1:0]            regulator_on,
	output logic                                       reg13_on,
	output logic [regbank_pkg::NUM_DVS-1:0]            phase_shift,
	output logic [regbank_pkg::NUM_REG-1:0]            output_discharge_enable
);
	import regbank_pkg::*;

	typedef struct packed {
		logic [NUM_REG-1:0][CODE_W-1:0] primary_voltage_code;
		logic [NUM_DVS-1:0][CODE_W-1:0] secondary_voltage_code;
		logic [NUM_REG-1:0]             on;
		logic [NUM_REG-1:0]             option;
		logic [NUM_REG-1:0]             fault_irq_enable;
		logic [NUM_REG-1:0]             fault_pend;
		logic                           reg13_on;
		logic                           button_press_irq_enable;
		logic                           button_release_irq_enable;
		logic [7:0]                     irq_source_address;
		logic [DATA_W-1:0]              rdata;
		logic                           rvalid;
		logic                           irq_n;
		logic [NUM_REG-1:0][CODE_W-1:0] lin_code;
		logic [NUM_REG-1:0]             discharge;
	} bank_t;

	// switchers have no discharge path, so their lanes are masked off
	localparam logic [NUM_REG-1:0] LINEAR_MASK = {{(NUM_REG-NUM_DVS){1'b1}}, {NUM_DVS{1'b0}}};

	bank_t                          state_r;
	bank_t                          state_nxt;
	logic [NUM_DVS-1:0][CODE_W-1:0] dvs_code;
	logic                           button_press_irq_flag;
	logic                           release_flag;
	logic                           button_live;
	logic                           button_evt;
	logic                           status_read;
	logic [DATA_W-1:0]              rd_mux;
	logic [NUM_REG-1:0]             fault_evt;

	// =========================================================
	// submodules
	dvs_select #(
		.N (NUM_DVS),
		.W (CODE_W)
	) u_dvs (
		.clk       (clk),
		.rst       (rst),
		.primary   (state_r.primary_voltage_code[NUM_DVS-1:0]),
		.secondary (state_r.secondary_voltage_code),
		.bank_sel  (voltage_bank_select_pin),
		.applied   (dvs_code)
	);

	// reading button status clears its sticky flags
	assign status_read = reg_req.rd && (reg_req.addr == OFS_BUTTON_STATUS);

	button_event u_btn (
		.clk                 (clk),
		.rst                 (rst),
		.push_button_input_n (push_button_input_n),
		.press_en            (state_r.button_press_irq_enable),
		.release_en          (state_r.button_release_irq_enable),
		.flag_clear          (status_read),
		.press_flag          (button_press_irq_flag),
		.release_flag        (release_flag),
		.live                (button_live),
		.event_pulse         (button_evt)
	);

	// only faults with their enable set count as events
	assign fault_evt = regulator_fault & state_r.fault_irq_enable; // R5

	// =========================================================
	// read multiplexer; unmapped addresses read zero
	always_comb
	begin
		rd_mux = '0;
		for (int i = 0; i < NUM_REG; i++)
		begin
			if (reg_req.addr == OFS_VOLT[i])
				rd_mux = {2'b00, state_r.primary_voltage_code[i]}; // R8 R13
			if (reg_req.addr == OFS_CTRL[i])
				rd_mux = {state_r.on[i], 4'h0, state_r.option[i],
					state_r.fault_irq_enable[i], power_good[i]}; // R6 R13
		end
		for (int j = 0; j < NUM_DVS; j++)
		begin
			if (reg_req.addr == OFS_SEC[j])
				rd_mux = {2'b00, state_r.secondary_voltage_code[j]};
		end
		case (reg_req.addr)
			OFS_REG13_ENABLE:  rd_mux = {state_r.reg13_on, 7'h00};
			OFS_BUTTON_CTRL:   rd_mux = {state_r.button_press_irq_enable,
				state_r.button_release_irq_enable, 6'h00};
			OFS_IRQ_SOURCE:    rd_mux = state_r.irq_source_address;
			OFS_BUTTON_STATUS: rd_mux = {button_press_irq_flag, release_flag,
				button_live, 5'h00}; // R11
			default:           ;
		endcase
	end

	// =========================================================
	// register writes, sticky fault capture and irq source tracking
	always_comb
	begin
		state_nxt        = state_r;
		state_nxt.rvalid = reg_req.rd;
		state_nxt.rdata  = reg_req.rd ? rd_mux : state_r.rdata;

		// host writes touch only the defined fields
		if (reg_req.wr)
		begin
			for (int i = 0; i < NUM_REG; i++)
			begin
				if (reg_req.addr == OFS_VOLT[i])
					state_nxt.primary_voltage_code[i] = reg_req.wdata[CODE_W-1:0]; // R8
				if (reg_req.addr == OFS_CTRL[i])
				begin
					state_nxt.on[i]               = reg_req.wdata[BIT_ON];     // R3
					state_nxt.option[i]           = reg_req.wdata[BIT_OPTION]; // R4 R7
					state_nxt.fault_irq_enable[i] = reg_req.wdata[BIT_FLT_EN]; // R5
				end
			end
			for (int j = 0; j < NUM_DVS; j++)
			begin
				if (reg_req.addr == OFS_SEC[j])
					state_nxt.secondary_voltage_code[j] = reg_req.wdata[CODE_W-1:0];
			end
			if (reg_req.addr == OFS_REG13_ENABLE)
				state_nxt.reg13_on = reg_req.wdata[BIT_ON]; // R3
			if (reg_req.addr == OFS_BUTTON_CTRL)
			begin
				state_nxt.button_press_irq_enable   = reg_req.wdata[BIT_PRESS];   // R9
				state_nxt.button_release_irq_enable = reg_req.wdata[BIT_RELEASE]; // R10
			end
		end

		// reading a control register clears its pending fault
		if (reg_req.rd)
		begin
			for (int i = 0; i < NUM_REG; i++)
			begin
				if (reg_req.addr == OFS_CTRL[i])
					state_nxt.fault_pend[i] = 1'b0;
			end
			if (reg_req.addr == OFS_IRQ_SOURCE)
				state_nxt.irq_source_address = IRQ_NONE; // R12
		end

		// events are applied last so they win over a same-cycle clear
		state_nxt.fault_pend = state_nxt.fault_pend | fault_evt;
		if (button_evt)
			state_nxt.irq_source_address = OFS_BUTTON_CTRL; // R12
		for (int i = NUM_REG - 1; i >= 0; i--)
		begin
			if (fault_evt[i] && !state_r.fault_pend[i])
				state_nxt.irq_source_address = OFS_CTRL[i]; // R12
		end

		// linear regulators use their single code directly
		state_nxt.lin_code = state_nxt.primary_voltage_code;

		// discharge registered with the enable so the output never glitches
		state_nxt.discharge = state_nxt.option & LINEAR_MASK & ~state_nxt.on; // R7

		// interrupt stays low while any enabled source is pending
		state_nxt.irq_n = ~(|(state_nxt.fault_pend & state_nxt.fault_irq_enable)
			| (button_press_irq_flag & state_r.button_press_irq_enable)
			| (release_flag & state_r.button_release_irq_enable)
			| button_evt); // R14
	end

	// =========================================================
	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r                           <= '0;
			state_r.primary_voltage_code      <= RST_CODE;
			state_r.lin_code                  <= RST_CODE;
			state_r.secondary_voltage_code    <= RST_SEC;
			state_r.on                        <= RST_ON;
			state_r.option                    <= RST_OPTION;
			state_r.fault_irq_enable          <= RST_FLT_EN;
			state_r.reg13_on                  <= RST_REG13;
			state_r.irq_source_address        <= IRQ_NONE; // R12
			state_r.irq_n                     <= 1'b1;
			state_r.discharge                 <= RST_OPTION & LINEAR_MASK & ~RST_ON;
		end
		else
			state_r <= state_nxt;
	end

	// =========================================================
	// outputs; switcher codes come from the registered selector
	always_comb
	begin
		output_voltage_code                = state_r.lin_code;
		output_voltage_code[NUM_DVS-1:0]   = dvs_code; // R1 R2
	end

	assign reg_rsp.rdata             = state_r.rdata;
	assign reg_rsp.valid             = state_r.rvalid;
	assign irq_n                     = state_r.irq_n;
	assign regulator_on              = state_r.on;          // R3
	assign reg13_on                  = state_r.reg13_on;    // R3
	assign phase_shift               = state_r.option[NUM_DVS-1:0]; // R4
	assign output_discharge_enable   = state_r.discharge;   // R7
endmodule
`default_nettype wire

// *** regbank_chk.sv ***
// checker for the regulator register bank, bound to its top
// assumes single-cycle read and write strobes on the register port
`timescale 1ns/1ps
`default_nettype none
module regbank_chk (
	// clock and reset
	input wire logic                                 clk,
	input wire logic                                 rst,
	// register port
	input wire regbank_pkg::reg_req_t                reg_req,
	input wire regbank_pkg::reg_rsp_t                reg_rsp,
	// status, pins and controls
	input wire logic [regbank_pkg::NUM_REG-1:0]      power_good,
	input wire logic                                 voltage_bank_select_pin,
	input wire logic                                 irq_n,
	input wire logic [regbank_pkg::NUM_REG-1:0][5:0] output_voltage_code,
	input wire logic [regbank_pkg::NUM_REG-1:0]      regulator_on,
	input wire logic                                 reg13_on,
	input wire logic [regbank_pkg::NUM_DVS-1:0]      phase_shift,
	input wire logic [regbank_pkg::NUM_REG-1:0]      output_discharge_enable
);
	import regbank_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// =========================================================
	// switcher code: write then a held pin, selector adds a flop
	sequence sec_write_held;
		reg_req.wr && reg_req.addr == 8'h31 && voltage_bank_select_pin
			##1 voltage_bank_select_pin && !reg_req.wr;
	endsequence
	bank_high_a: assert property (sec_write_held |=>
		output_voltage_code[0] == $past(reg_req.wdata[5:0], 2))
		else $error("secondary code not applied");
	sequence prim_write_held;
		reg_req.wr && reg_req.addr == 8'h30 && !voltage_bank_select_pin
			##1 !voltage_bank_select_pin && !reg_req.wr;
	endsequence
	bank_low_a: assert property (prim_write_held |=>
		output_voltage_code[0] == $past(reg_req.wdata[5:0], 2))
		else $error("primary code not applied");
	// =========================================================
	// register fields
	pgood_read_a: assert property (reg_req.rd && reg_req.addr == 8'h51 |=>
		reg_rsp.valid && reg_rsp.rdata[0] == $past(power_good[2]))
		else $error("power good bit wrong");
	rail13_on_a: assert property (reg_req.wr && reg_req.addr == 8'hB1 |=>
		reg13_on == $past(reg_req.wdata[7]))
		else $error("rail 13 enable wrong");
	ldo_code_a: assert property (reg_req.wr && reg_req.addr == 8'h58 |=>
		output_voltage_code[3] == $past(reg_req.wdata[5:0]))
		else $error("linear code wrong");
	phase_bit_a: assert property (reg_req.wr && reg_req.addr == 8'h42 |=>
		phase_shift[1] == $past(reg_req.wdata[2]))
		else $error("phase bit wrong");
	rsvd_zero_a: assert property (reg_req.rd && reg_req.addr == 8'hB1 |=>
		reg_rsp.rdata[6:0] == 7'h00)
		else $error("reserved bits not zero");
	// discharge only on linears and only while off
	discharge_off_a: assert property (
		(output_discharge_enable & regulator_on) == '0 && output_discharge_enable[1:0] == 2'h0)
		else $error("discharge while on");
	// a pending interrupt only goes away after a read
	irq_sticky_a: assert property (!irq_n && !reg_req.rd && !$past(reg_req.rd) |=> !irq_n)
		else $error("interrupt dropped");
endmodule
bind regbank_top regbank_chk chk (.clk(clk), .rst(rst), .reg_req(reg_req),
	.reg_rsp(reg_rsp), .power_good(power_good), .irq_n(irq_n),
	.voltage_bank_select_pin(voltage_bank_select_pin), .reg13_on(reg13_on),
	.output_voltage_code(output_voltage_code), .regulator_on(regulator_on),
	.phase_shift(phase_shift), .output_discharge_enable(output_discharge_enable));
`default_nettype wire

// *** host_model.sv ***
// host side model: single-byte register reads and writes
// assumes its tasks are entered 1 ns after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock
	input  wire logic                  clk,
	// register port
	output var regbank_pkg::reg_req_t  reg_req,
	input  wire regbank_pkg::reg_rsp_t reg_rsp
);
	import regbank_pkg::*;
	initial reg_req = '0;
	// write strobe held to the taking edge, then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		#1 reg_req.wr = 1'b0;
		@(posedge clk);
		#1;
	endtask
	// read strobe; answer is settled 1 ns after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		#1 reg_req.rd = 1'b0;
		v = reg_rsp.valid;
		d = reg_rsp.rdata;
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// bench for the regulator register bank
// assumes the host model drives the port and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module tb;
	import regbank_pkg::*;
	// =========================================================
	// signals
	localparam logic [9:0][5:0] DEF_CODE = {6'h24, 6'h24, 6'h18, 6'h18, 6'h24,
		6'h39, 6'h39, 6'h34, 6'h39, 6'h19};
	logic                           clk = 1'b0;
	logic                           rst = 1'b1;
	reg_req_t                       req;
	reg_rsp_t                       rsp;
	logic [NUM_REG-1:0]             pg = 10'h2A7;
	logic [NUM_REG-1:0]             flt = 10'h000;
	logic                           sel = 1'b0;
	logic                           btn_n = 1'b1;
	logic                           irq_n;
	logic                           r13;
	logic [NUM_REG-1:0][CODE_W-1:0] code;
	logic [NUM_REG-1:0]             on;
	logic [NUM_REG-1:0]             dis;
	logic [NUM_DVS-1:0]             ph;
	logic [7:0]                     d;
	logic                           v;
	int                             miscompares = 0;
	int                             checks = 0;
	always #12.5 clk = ~clk;
	regbank_top dut (.clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp),
		.power_good(pg), .regulator_fault(flt), .voltage_bank_select_pin(sel),
		.push_button_input_n(btn_n), .irq_n(irq_n), .output_voltage_code(code),
		.regulator_on(on), .reg13_on(r13), .phase_shift(ph),
		.output_discharge_enable(dis));
	host_model host (.clk(clk), .reg_req(req), .reg_rsp(rsp));
	// =========================================================
	// helpers
	task automatic cmp(input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// a read must answer with valid and the expected byte
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d, v);
		cmp({1'b0, v, d}, {2'h1, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// =========================================================
	// scenarios
	// every primary voltage and control register after reset
	task automatic t_defaults();
		logic [9:0] onr;
		onr = 10'h38F;
		for (int i = 0; i < NUM_REG; i++)
		begin
			rchk(OFS_VOLT[i], {2'h0, DEF_CODE[i]});
			rchk(OFS_CTRL[i], {onr[i], 5'h01, 1'b0, pg[i]});
		end
		cmp(on, onr);
		cmp(dis, 10'h070);
		cmp(ph, 2'h3);
		rchk(8'hB1, 8'h80);
		rchk(8'hC1, 8'hFF);
		rchk(8'h33, 8'h00);
	endtask
	// writes to enable, phase, discharge, reserved and status bits
	task automatic t_fields();
		host.wr(8'h42, 8'h7A);
		rchk(8'h42, {7'h01, pg[1]});
		cmp({on[1], ph[1]}, 2'h0);
		host.wr(8'h61, 8'h84);
		cmp(dis[4], 1'b0);
		rchk(8'h61, {7'h42, pg[4]});
		host.wr(8'hB1, 8'h7F);
		rchk(8'hB1, 8'h00);
		cmp(r13, 1'b0);
		host.wr(8'h58, 8'hFF);
		rchk(8'h58, 8'h3F);
		cmp(code[3], 6'h3F);
	endtask
	// pin picks the switcher code; selector costs one more edge
	task automatic t_bank();
		host.wr(8'h30, 8'h05);
		host.wr(8'h31, 8'h2A);
		cyc(2);
		cmp(code[0], 6'h05);
		sel = 1'b1;
		cyc(3);
		cmp(code[0], 6'h2A);
		host.wr(8'h31, 8'h15);
		cmp(code[0], 6'h15);
		sel = 1'b0;
		cyc(3);
		cmp(code[0], 6'h05);
	endtask
	// press and release interrupts, each behind its own enable
	task automatic t_button();
		host.wr(8'hC0, 8'h80);
		rchk(8'hC0, 8'h80);
		btn_n = 1'b0;
		cyc(4);
		cmp(irq_n, 1'b0);
		rchk(8'hC1, 8'hC0);
		rchk(8'hC1, 8'hFF);
		rchk(8'hC2, 8'hA0);
		cmp(irq_n, 1'b1);
		btn_n = 1'b1;
		cyc(4);
		cmp(irq_n, 1'b1);
		host.wr(8'hC0, 8'h40);
		btn_n = 1'b0;
		cyc(2);
		btn_n = 1'b1;
		cyc(4);
		cmp(irq_n, 1'b0);
		rchk(8'hC2, 8'h40);
	endtask
	// a fault only interrupts once its enable is set
	task automatic t_fault();
		flt[5] = 1'b1;
		cyc(4);
		cmp(irq_n, 1'b1);
		host.wr(8'h69, 8'h06);
		cmp(dis[5], 1'b1);
		cyc(2);
		cmp(irq_n, 1'b0);
		rchk(8'hC1, 8'h69);
		flt[5] = 1'b0;
		rchk(8'h69, {7'h03, pg[5]});
		cmp(irq_n, 1'b1);
	endtask
	// =========================================================
	// main sequence and watchdog
	initial
	begin
		cyc(5);
		rst = 1'b0;
		cyc(1);
		t_defaults();
		t_fields();
		t_bank();
		t_button();
		t_fault();
		print_verdict();
	end
	initial
	begin
		#(25 * 3000);
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
